// file: verilog/csw_clock_ctrl.sv
// Clock source selection, gear, prescaler, core clock gating and warm-up timer.
// Assumes oscillator and multiplier clocks arrive as levels synchronous to REF_CLK.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - multiplier select bit, reset 0, picks raw oscillator or multiplied clock.
// - system select bit, reset 0, picks high-speed or low-speed clock.
// - status bit shows system source, changing only after the switch finishes.
// - multiplier clock runs at four times the oscillator clock.
// - gear gives the high-speed clock divided by 1, 2, 4 or 8.
// - prescaler clock is the peripheral base divided by 1, 2, 4, 8, 16 or 32.
// - core clocks come from system clock, stopped in idle, sleep, stop.
// - tick timer clock is the high-speed oscillator divided by 32.
// - reset runs both oscillators, stops multiplier, gear undivided.
// - multiplier stays off until its run enable is written 1.
// - wake from stop or sleep starts warm-up; core resumes when done.
// - multiplier disabled during stop and sleep.
// - warm-up counts high-speed oscillator on 0, low-speed on 1.
// - 3-bit warm-up code sets count length; code 0 means none.
// - writing start begins warm-up; flag reads 1 while counting.
module csw_clock_ctrl #(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          REF_CLK,
    input  wire logic          RESET_N,
    // Register port
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [31:0]   WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic [31:0]        RDATA,
    // Oscillator and multiplier levels
    input  wire logic          HS_OSC_CLK,
    input  wire logic          LS_OSC_CLK,
    input  wire logic          MULT_CLK,
    // Power mode and wake
    input  wire logic          LP_IDLE,
    input  wire logic          LP_SLEEP,
    input  wire logic          LP_STOP,
    input  wire logic          WAKE,
    // Oscillator and multiplier enables
    output logic               HS_OSC_EN,
    output logic               LS_OSC_EN,
    output logic               MULT_RUN,
    // Derived clocks
    output logic               HIGH_SPEED_CLK,
    output logic               GEAR_CLK,
    output logic               SYS_CLK,
    output logic               PRESCALER_CLK,
    output logic               CORE_HCLK,
    output logic               CORE_FREE_CLK,
    output logic               TICK_TIMER_CLK
);

    csw_pkg::csw_cfg_t                    cfg_r;
    logic                                 hs_clk;
    logic                                 sys_clk;
    logic                                 sys_cur;
    logic                                 hs_prev_r;
    logic                                 ls_prev_r;
    logic                                 hsc_prev_r;
    logic                                 per_prev_r;
    logic [csw_pkg::GEAR_CNT_W-1:0]       gear_cnt_r;
    logic [csw_pkg::PRESC_CNT_W-1:0]      presc_cnt_r;
    logic [csw_pkg::TICK_CNT_W-1:0]       tick_cnt_r;
    logic [csw_pkg::WU_CNT_W-1:0]         wu_cnt_r;
    logic [csw_pkg::WU_CNT_W-1:0]         wu_target;
    logic                                 wu_active_r;
    logic                                 wake_hold_r;
    logic                                 core_en_r;
    logic                                 gear_clk_r;
    logic                                 presc_clk_r;
    logic                                 wr_osc;
    logic                                 wu_go;
    logic                                 wu_edge;
    logic                                 per_clk;
    logic                                 run_ok;
    logic                                 deep_sleep;

    assign wr_osc     = WR && ADDR == AW'(csw_pkg::OFF_OSC_CTRL);
    assign wu_go      = (wr_osc && WDATA[csw_pkg::OSC_WU_GO_BIT]) || WAKE;
    assign deep_sleep = LP_SLEEP || LP_STOP;
    assign run_ok     = !(LP_IDLE || deep_sleep || WAKE) && !wake_hold_r;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_r <= csw_pkg::CFG_RESET;
        end else if (WR) begin
            if (wr_osc) begin
                cfg_r.ls_en   <= WDATA[csw_pkg::OSC_LS_EN_BIT];
                cfg_r.hs_en   <= WDATA[csw_pkg::OSC_HS_EN_BIT];
                cfg_r.wu_time <= WDATA[csw_pkg::OSC_WU_TIME_LO +: 3];
                cfg_r.wu_ls   <= WDATA[csw_pkg::OSC_WU_LS_BIT];
                cfg_r.pll_run <= WDATA[csw_pkg::OSC_PLL_RUN_BIT];
            end
            if (ADDR == AW'(csw_pkg::OFF_PLL_SEL)) begin
                cfg_r.pll_use <= WDATA[csw_pkg::PLL_USE_BIT];
            end
            if (ADDR == AW'(csw_pkg::OFF_SYS_SEL)) begin
                cfg_r.sys_ls <= WDATA[csw_pkg::SYS_LS_BIT];
            end
            if (ADDR == AW'(csw_pkg::OFF_SYS_CTRL)) begin
                cfg_r.gear   <= WDATA[csw_pkg::SC_GEAR_LO +: 2];
                cfg_r.per_hs <= WDATA[csw_pkg::SC_PER_HS_BIT];
                cfg_r.prck   <= WDATA[csw_pkg::SC_PRCK_LO +: 3];
            end
        end
    end

    // Read data stand for exactly one cycle; unmapped offsets read zero
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= 32'h0000_0000;
            if (RD) begin
                unique case (ADDR)
                    AW'(csw_pkg::OFF_OSC_CTRL): begin
                        RDATA[csw_pkg::OSC_LS_EN_BIT]      <= cfg_r.ls_en;
                        RDATA[csw_pkg::OSC_HS_EN_BIT]      <= cfg_r.hs_en;
                        RDATA[csw_pkg::OSC_WU_TIME_LO +: 3] <= cfg_r.wu_time;
                        RDATA[csw_pkg::OSC_WU_LS_BIT]      <= cfg_r.wu_ls;
                        RDATA[csw_pkg::OSC_PLL_RUN_BIT]    <= cfg_r.pll_run;
                        RDATA[csw_pkg::OSC_WU_ACT_BIT]     <= wu_active_r;
                    end
                    AW'(csw_pkg::OFF_PLL_SEL): RDATA[csw_pkg::PLL_USE_BIT] <= cfg_r.pll_use;
                    AW'(csw_pkg::OFF_SYS_SEL): begin
                        RDATA[csw_pkg::SYS_LS_BIT]     <= cfg_r.sys_ls;
                        RDATA[csw_pkg::SYS_STATUS_BIT] <= sys_cur;
                    end
                    AW'(csw_pkg::OFF_SYS_CTRL): begin
                        RDATA[csw_pkg::SC_GEAR_LO +: 2]  <= cfg_r.gear;
                        RDATA[csw_pkg::SC_PER_HS_BIT]    <= cfg_r.per_hs;
                        RDATA[csw_pkg::SC_PRCK_LO +: 3]  <= cfg_r.prck;
                    end
                    default: RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            HS_OSC_EN <= 1'b1;
            LS_OSC_EN <= 1'b1;
            MULT_RUN  <= 1'b0;
        end else begin
            HS_OSC_EN <= cfg_r.hs_en;
            LS_OSC_EN <= cfg_r.ls_en;
            MULT_RUN  <= cfg_r.pll_run && !deep_sleep;
        end
    end

    // the quadrupled clock enters on MULT_CLK from the analog multiplier
    csw_clock_switch u_hs_switch (
        .clk       (REF_CLK),
        .rst_n     (RESET_N),
        .src0      (HS_OSC_CLK),
        .src1      (MULT_CLK),
        .sel       (cfg_r.pll_use),
        .clk_out_r (hs_clk),
        .cur_r     ()
    );

    assign HIGH_SPEED_CLK = hs_clk;

    // Edge history of the sampled clock levels
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hs_prev_r  <= 1'b0;
            ls_prev_r  <= 1'b0;
            hsc_prev_r <= 1'b0;
            per_prev_r <= 1'b0;
        end else begin
            hs_prev_r  <= HS_OSC_CLK;
            ls_prev_r  <= LS_OSC_CLK;
            hsc_prev_r <= hs_clk;
            per_prev_r <= per_clk;
        end
    end

    // clock gear
    // Changing the gear mid-count may give one odd phase; keep consumers idle then
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gear_cnt_r <= '0;
            gear_clk_r <= 1'b0;
        end else begin
            if (hs_clk && !hsc_prev_r) begin
                gear_cnt_r <= gear_cnt_r + 1'b1;
            end
            gear_clk_r <= (cfg_r.gear == 2'h0) ? hs_clk : gear_cnt_r[cfg_r.gear - 2'h1];
        end
    end

    assign GEAR_CLK = gear_clk_r;

    csw_clock_switch u_sys_switch (
        .clk       (REF_CLK),
        .rst_n     (RESET_N),
        .src0      (gear_clk_r),
        .src1      (LS_OSC_CLK),
        .sel       (cfg_r.sys_ls),
        .clk_out_r (sys_clk),
        .cur_r     (sys_cur)
    );

    assign SYS_CLK = sys_clk;

    assign per_clk = cfg_r.per_hs ? hs_clk : gear_clk_r;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            presc_cnt_r <= '0;
            presc_clk_r <= 1'b0;
        end else begin
            if (per_clk && !per_prev_r) begin
                presc_cnt_r <= presc_cnt_r + 1'b1;
            end
            if (cfg_r.prck == 3'h0 || cfg_r.prck > 3'h5) begin
                presc_clk_r <= per_clk;
            end else begin
                presc_clk_r <= presc_cnt_r[cfg_r.prck - 3'h1];
            end
        end
    end

    assign PRESCALER_CLK = presc_clk_r;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt_r     <= '0;
            TICK_TIMER_CLK <= 1'b0;
        end else begin
            if (HS_OSC_CLK && !hs_prev_r) begin
                tick_cnt_r <= tick_cnt_r + 1'b1;
            end
            TICK_TIMER_CLK <= tick_cnt_r[csw_pkg::TICK_CNT_W-1];
        end
    end

    // core clock gating
    // Enable only moves while the system clock is low, so no high phase is cut
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            core_en_r     <= 1'b1;
            CORE_HCLK     <= 1'b0;
            CORE_FREE_CLK <= 1'b0;
        end else begin
            if (!sys_clk) begin
                core_en_r <= run_ok;
            end
            CORE_HCLK     <= sys_clk && core_en_r;
            CORE_FREE_CLK <= sys_clk && core_en_r;
        end
    end

    always_comb begin
        wu_target = '0;
        if (!cfg_r.wu_ls) begin
            wu_target[csw_pkg::WU_HS_EXP_BASE + int'(cfg_r.wu_time)] = 1'b1;
        end else if (cfg_r.wu_time < csw_pkg::WU_LS_LONG_FROM) begin
            wu_target[csw_pkg::WU_LS_EXP_SHORT + int'(cfg_r.wu_time)] = 1'b1;
        end else begin
            wu_target[csw_pkg::WU_LS_EXP_LONG + int'(cfg_r.wu_time)] = 1'b1;
        end
    end

    assign wu_edge = cfg_r.wu_ls ? (LS_OSC_CLK && !ls_prev_r) : (HS_OSC_CLK && !hs_prev_r);

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wu_cnt_r    <= '0;
            wu_active_r <= 1'b0;
        end else if (wu_go) begin
            wu_cnt_r    <= '0;
            wu_active_r <= wr_osc ? (WDATA[csw_pkg::OSC_WU_TIME_LO +: 3] != 3'h0)
                                  : (cfg_r.wu_time != 3'h0);
        end else if (wu_active_r && wu_edge) begin
            wu_cnt_r <= wu_cnt_r + 1'b1;
            if (wu_cnt_r + 1'b1 == wu_target) begin
                wu_active_r <= 1'b0;
            end
        end
    end

    // wake holds core clocks until warm-up ends
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wake_hold_r <= 1'b0;
        end else if (WAKE) begin
            wake_hold_r <= 1'b1;
        end else if (!wu_active_r) begin
            wake_hold_r <= 1'b0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    AST_RESET_STATE: assert property (
        $rose(RESET_N) |-> !cfg_r.pll_use && !cfg_r.sys_ls && cfg_r.gear == 2'h0 && !MULT_RUN)
        else $error("reset state wrong");
    AST_MULT_OFF_DEEP: assert property (deep_sleep |=> !MULT_RUN)
        else $error("multiplier runs in sleep or stop");
    AST_MULT_NEEDS_EN: assert property (MULT_RUN |-> $past(cfg_r.pll_run))
        else $error("multiplier runs without enable");
    AST_STATUS_AFTER_SWITCH: assert property ($changed(sys_cur) |-> sys_cur == cfg_r.sys_ls)
        else $error("status changed away from request");
    AST_WU_START: assert property (wr_osc && WDATA[csw_pkg::OSC_WU_GO_BIT] &&
        WDATA[csw_pkg::OSC_WU_TIME_LO +: 3] == 3'h0 |=> !wu_active_r)
        else $error("code zero warm-up should finish at once");
    AST_WU_LENGTH: assert property ($fell(wu_active_r) && !$past(wu_go) |->
        $past(wu_cnt_r) + 1'b1 == $past(wu_target))
        else $error("warm-up ended at wrong count");
    AST_CORE_FROM_SYS: assert property (CORE_HCLK |-> $past(sys_clk) && $past(core_en_r))
        else $error("core clock high without system clock");
    AST_TICK_DIV: assert property ($rose(TICK_TIMER_CLK) |-> $past(tick_cnt_r) == 5'h10)
        else $error("tick clock rose at wrong count");
    AST_GEAR_BYPASS: assert property ($past(cfg_r.gear) == 2'h0 |-> GEAR_CLK == $past(hs_clk))
        else $error("undivided gear does not follow high-speed clock");
    AST_WAKE_HOLD: assert property (
        WAKE && cfg_r.wu_time != 3'h0 |=> wake_hold_r && wu_active_r && !run_ok)
        else $error("wake did not start warm-up hold");

    COV_WAKE: cover property ($fell(wake_hold_r));
    COV_SYS_SWITCH: cover property ($rose(sys_cur));
    COV_WU_DONE: cover property ($fell(wu_active_r));
    COV_MULT_USE: cover property ($rose(cfg_r.pll_use) ##[1:100] MULT_RUN);

endmodule

// file: verilog/csw_pkg.sv
// Constants, register layout and types of the clock select and warm-up block.
// Assumes a plain single-cycle register port with byte addresses.
package csw_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFF_PLL_SEL  = 8'h04;
    localparam logic [7:0] OFF_SYS_SEL  = 8'h08;
    localparam logic [7:0] OFF_SYS_CTRL = 8'h0C;

    // Oscillator control field positions
    localparam int OSC_LS_EN_BIT  = 9;
    localparam int OSC_HS_EN_BIT  = 8;
    localparam int OSC_WU_TIME_LO = 4;
    localparam int OSC_WU_LS_BIT  = 3;
    localparam int OSC_PLL_RUN_BIT = 2;
    localparam int OSC_WU_ACT_BIT = 1;
    localparam int OSC_WU_GO_BIT  = 0;

    // Source select field positions
    localparam int PLL_USE_BIT    = 0;
    localparam int SYS_LS_BIT     = 1;
    localparam int SYS_STATUS_BIT = 0;

    // System control field positions
    localparam int SC_GEAR_LO   = 0;
    localparam int SC_PER_HS_BIT = 12;
    localparam int SC_PRCK_LO   = 8;

    // Divider and warm-up counter widths
    localparam int GEAR_CNT_W  = 3;
    localparam int PRESC_CNT_W = 5;
    localparam int TICK_CNT_W  = 5;
    localparam int WU_CNT_W    = 19;

    // Warm-up exponent offsets: high-speed 2^(9+code), low-speed short 2^(5+code), long 2^(11+code)
    localparam int WU_HS_EXP_BASE  = 9;
    localparam int WU_LS_EXP_SHORT = 5;
    localparam int WU_LS_EXP_LONG  = 11;
    localparam logic [2:0] WU_LS_LONG_FROM = 3'h4;

    typedef struct packed {
        logic       ls_en;
        logic       hs_en;
        logic [2:0] wu_time;
        logic       wu_ls;
        logic       pll_run;
        logic       pll_use;
        logic       sys_ls;
        logic [1:0] gear;
        logic       per_hs;
        logic [2:0] prck;
    } csw_cfg_t;

    // Both oscillators run, multiplier off, everything on the raw oscillator
    localparam csw_cfg_t CFG_RESET = '{
        ls_en: 1'b1, hs_en: 1'b1, wu_time: 3'h0, wu_ls: 1'b0, pll_run: 1'b0,
        pll_use: 1'b0, sys_ls: 1'b0, gear: 2'h0, per_hs: 1'b0, prck: 3'h0};

    typedef enum logic [1:0] {
        SW_FOLLOW   = 2'b00,
        SW_DRAIN    = 2'b01,
        SW_WAIT_NEW = 2'b10
    } csw_sw_state_t;

endpackage

// file: verilog/csw_clock_switch.sv
// Glitch-free two-input clock selector working on sampled clock levels.
// Assumes both source levels are synchronous to clk.
`timescale 1ns/1ps
module csw_clock_switch (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Sources and request
    input  wire logic src0,
    input  wire logic src1,
    input  wire logic sel,
    // Switched clock and current source
    output logic      clk_out_r,
    output logic      cur_r
);

    csw_pkg::csw_sw_state_t state_r;
    csw_pkg::csw_sw_state_t state_nxt;
    logic                   old_lvl;
    logic                   new_lvl;

    assign old_lvl = cur_r ? src1 : src0;
    assign new_lvl = cur_r ? src0 : src1;

    // no short phases
    // Output goes low only with the old source, and follows the new one from its low phase
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            csw_pkg::SW_FOLLOW: begin
                if (sel != cur_r) begin
                    state_nxt = csw_pkg::SW_DRAIN;
                end
            end
            csw_pkg::SW_DRAIN: begin
                if (!old_lvl) begin
                    state_nxt = csw_pkg::SW_WAIT_NEW;
                end
            end
            csw_pkg::SW_WAIT_NEW: begin
                if (!new_lvl) begin
                    state_nxt = csw_pkg::SW_FOLLOW;
                end
            end
            default: state_nxt = csw_pkg::SW_FOLLOW;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= csw_pkg::SW_FOLLOW;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= 1'b0;
        end else if (state_r == csw_pkg::SW_WAIT_NEW && !new_lvl) begin
            cur_r <= ~cur_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_out_r <= 1'b0;
        end else if (state_r == csw_pkg::SW_WAIT_NEW) begin
            clk_out_r <= 1'b0;
        end else begin
            clk_out_r <= old_lvl;
        end
    end

    AST_SW_HOLD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == csw_pkg::SW_WAIT_NEW |=> !clk_out_r)
        else $error("switch output high while waiting for new source");

    AST_SW_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == csw_pkg::SW_FOLLOW |=> clk_out_r == $past(old_lvl))
        else $error("switch output does not follow current source");

endmodule

// file: tb/csw_osc_model.sv
// Oscillator and multiplier stand-in for the clock control block.
// Assumes REF_CLK at 100 MHz; levels move just after its rising edge.
`timescale 1ns/1ps
module csw_osc_model (
    // Clock and reset
    input  wire logic REF_CLK,
    input  wire logic RESET_N,
    // Enables from the block
    input  wire logic HS_OSC_EN,
    input  wire logic LS_OSC_EN,
    input  wire logic MULT_RUN,
    // Oscillator levels
    output logic      HS_OSC_CLK,
    output logic      LS_OSC_CLK,
    output logic      MULT_CLK
);
    logic [4:0] cnt_r;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // Stopped sources stand still low
    assign HS_OSC_CLK = HS_OSC_EN & cnt_r[2];
    assign LS_OSC_CLK = LS_OSC_EN & cnt_r[4];
    assign MULT_CLK   = MULT_RUN & cnt_r[0];
endmodule

// file: tb/clock_select_and_warmup_tb.sv
// Self-checking bench for the clock select and warm-up block.
// Assumes oscillator model in tb/; periods are counted in REF_CLK cycles.
`timescale 1ns/1ps
module clock_select_and_warmup_tb;
    logic        REF_CLK, RESET_N, WR, RD, LP_IDLE, LP_SLEEP, LP_STOP, WAKE;
    logic [7:0]  ADDR;
    logic [31:0] WDATA, RDATA, d;
    logic        HS_OSC_CLK, LS_OSC_CLK, MULT_CLK, HS_OSC_EN, LS_OSC_EN, MULT_RUN;
    logic        HIGH_SPEED_CLK, GEAR_CLK, SYS_CLK, PRESCALER_CLK, TICK_TIMER_CLK;
    logic        CORE_HCLK, CORE_FREE_CLK, sys_q;
    int          mismatches, n_compared, cycles, p, c, run, min_ph;
    wire [4:0]   clks = {CORE_FREE_CLK, TICK_TIMER_CLK, PRESCALER_CLK, GEAR_CLK, HIGH_SPEED_CLK};

    csw_clock_ctrl #(.AW(8)) dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HS_OSC_CLK(HS_OSC_CLK),
        .LS_OSC_CLK(LS_OSC_CLK), .MULT_CLK(MULT_CLK), .LP_IDLE(LP_IDLE), .LP_SLEEP(LP_SLEEP),
        .LP_STOP(LP_STOP), .WAKE(WAKE), .HS_OSC_EN(HS_OSC_EN), .LS_OSC_EN(LS_OSC_EN),
        .MULT_RUN(MULT_RUN), .HIGH_SPEED_CLK(HIGH_SPEED_CLK), .GEAR_CLK(GEAR_CLK),
        .SYS_CLK(SYS_CLK), .PRESCALER_CLK(PRESCALER_CLK), .CORE_HCLK(CORE_HCLK),
        .CORE_FREE_CLK(CORE_FREE_CLK), .TICK_TIMER_CLK(TICK_TIMER_CLK));

    csw_osc_model osc (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HS_OSC_EN(HS_OSC_EN),
        .LS_OSC_EN(LS_OSC_EN), .MULT_RUN(MULT_RUN), .HS_OSC_CLK(HS_OSC_CLK),
        .LS_OSC_CLK(LS_OSC_CLK), .MULT_CLK(MULT_CLK));

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h", $time, m, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge REF_CLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge REF_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    // Cycles between the second and third rising edge; 0 if the clock stands
    task automatic meas(input int k);
        int  e;
        logic pv;
        e  = 0;
        c  = 0;
        p  = 0;
        pv = 1'b1;
        repeat (3000) begin
            @(posedge REF_CLK);
            #1;
            c++;
            if (clks[k] === 1'b1 && pv !== 1'b1) begin
                e++;
                if (e == 3) p = c;
                c = 0;
            end
            pv = clks[k];
            if (p > 0) break;
        end
    endtask

    task automatic poll(input logic [7:0] a, input int b, input logic v);
        c = 0;
        do begin
            rd(a);
            c += 2;
        end while (d[b] !== v && c < 70000);
    endtask

    // Tolerance covers oscillator phase at start and polling granularity
    task automatic wu(input logic [31:0] base, input logic [2:0] code, input logic ls, input int n);
        logic [31:0] cfg;
        cfg = base | (32'(ls) << 3) | (32'(code) << 4);
        wr(8'h00, cfg | 32'h1);
        rd(8'h00);
        chk(d, cfg | ((n > 0) ? 32'h2 : 32'h0), "warm-up flag");
        poll(8'h00, 1, 1'b0);
        chk(32'(c > n - 48 && c < n + 48), 32'h1, "warm-up length");
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    always @(posedge REF_CLK) begin
        cycles++;
        if (SYS_CLK === sys_q) begin
            run++;
        end else begin
            if (run < min_ph) min_ph = run;
            run = 1;
        end
        sys_q = SYS_CLK;
        if (CORE_HCLK !== CORE_FREE_CLK) begin
            mismatches++;
            $display("CHECK FAILED %0t core clocks differ", $time);
        end
        if (cycles == 90000) begin
            mismatches++;
            complete_run;
        end
    end

    initial begin
        {RESET_N, WR, RD, LP_IDLE, LP_SLEEP, LP_STOP, WAKE} = 7'h00;
        ADDR   = 8'h00;
        WDATA  = 32'h0;
        min_ph = 99;
        repeat (8) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(8'h00);
        chk(d, 32'h300, "osc ctrl reset");
        rd(8'h04);
        chk(d, 32'h0, "mult select reset");
        rd(8'h08);
        chk(d, 32'h0, "sys select reset");
        rd(8'h10);
        chk(d, 32'h0, "unmapped read");
        chk({29'h0, HS_OSC_EN, LS_OSC_EN, MULT_RUN}, 32'h6, "enables at reset");
        meas(3);
        chk(32'(p), 32'd256, "tick clock");
        $display("test reset and tick ends");
        for (int g = 0; g < 4; g++) begin
            wr(8'h0C, 32'(g));
            meas(1);
            chk(32'(p), 32'(8 << g), "gear period");
        end
        for (int k = 0; k < 6; k++) begin
            wr(8'h0C, 32'(k) << 8);
            meas(2);
            chk(32'(p), 32'(8 << k), "prescaler period");
        end
        wr(8'h0C, 32'h1103);
        meas(2);
        chk(32'(p), 32'd16, "prescaler on ungeared base");
        wr(8'h0C, 32'h0);
        $display("test dividers ends");
        wu(32'h300, 3'h0, 1'b0, 0);
        wu(32'h300, 3'h1, 1'b0, 8192);
        wu(32'h300, 3'h1, 1'b1, 2048);
        wu(32'h300, 3'h2, 1'b1, 4096);
        $display("test warm-up ends");
        wr(8'h00, 32'h304);
        rd(8'h00);
        chk({31'h0, MULT_RUN}, 32'h1, "multiplier run");
        wu(32'h304, 3'h2, 1'b0, 16384);
        wr(8'h04, 32'h1);
        meas(0);
        chk(32'(p), 32'd2, "multiplied clock in use");
        rd(8'h04);
        chk(d, 32'h1, "mult select readback");
        wr(8'h04, 32'h0);
        meas(0);
        chk(32'(p), 32'd8, "raw oscillator back");
        $display("test multiplier ends");
        min_ph = 99;
        wr(8'h08, 32'h2);
        poll(8'h08, 0, 1'b1);
        chk(d, 32'h3, "status low-speed");
        meas(4);
        chk(32'(p), 32'd32, "core on low-speed");
        wr(8'h08, 32'h0);
        poll(8'h08, 0, 1'b0);
        chk(d, 32'h0, "status high-speed");
        repeat (16) @(posedge REF_CLK);
        chk(32'(min_ph >= 4), 32'h1, "no short phase");
        $display("test system switch ends");
        @(posedge REF_CLK) LP_IDLE <= 1'b1;
        repeat (20) @(posedge REF_CLK);
        meas(4);
        chk(32'(p), 32'd0, "core stopped in idle");
        @(posedge REF_CLK) LP_IDLE <= 1'b0;
        meas(4);
        chk(32'(p), 32'd8, "core back after idle");
        wr(8'h00, 32'h314);
        LP_STOP <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        chk({31'h0, MULT_RUN}, 32'h0, "multiplier off in stop");
        WAKE    <= 1'b1;
        LP_STOP <= 1'b0;
        @(posedge REF_CLK);
        WAKE <= 1'b0;
        rd(8'h00);
        chk(d, 32'h316, "wake starts warm-up");
        meas(4);
        chk(32'(p), 32'd0, "core held during warm-up");
        poll(8'h00, 1, 1'b0);
        meas(4);
        chk(32'(p), 32'd8, "core after warm-up");
        chk({31'h0, MULT_RUN}, 32'h1, "multiplier after stop");
        $display("test low power ends");
        complete_run;
    end
endmodule
